// ---- design/dtr_core.v ----
// dual channel temperature readout core with alarms
`include "dtr_defs.vh"
// Operation
// - the serial state machine returns to idle when the clock stays low past the bus stall limit of 25 to 55 ms.
// - the overtemperature output pulls low while a temperature is above the programmed trip threshold.
// - the limit alarm asserts when local or remote temperature goes above its high or below its low limit.
// - the limit alarm latches until a status read or alert response acknowledges it with the fault gone.
// - when enabled, a shorted or open remote diode also asserts the limit alarm.
// - each temperature is 11 bits with a least bit worth one eighth degree.
// - main registers hold whole degrees unsigned and full scale ff marks a diode fault.
// - the three fraction bits sit in extended registers 10h remote and 11h local.
// - conversions run continuously at a programmed rate or singly on request.
// - every conversion covers both local and remote channels.
// - both channels are measured and reported even if one is unused.
// - each channel integrates for about 60 ms.
// - a full two-channel conversion takes nominally 125 ms from the stop bit.
// - setting the standby bit halts autonomous conversions while single shots still work.
// - main and extended registers of a channel update in the same cycle.
module dtr_core #(
  parameter TIMEOUT_CYC = `DTR_TIMEOUT_CYC,
  parameter INTEG_CYC = `DTR_INTEG_CYC,
  parameter CONV_CYC = `DTR_CONV_CYC,
  parameter RATE_UNIT_CYC = `DTR_CONV_CYC
) (
  input wire clk_in,                   // 200 mhz core clock
  input wire rst_in,                   // async reset, high
  input wire scl_in,                   // serial clock pin level
  input wire sda_in,                   // serial data pin level
  output wire sda_out,                 // serial data drive value (0)
  output wire sda_oe_out,              // serial data pulled low
  output wire overtemp_trip_n_out,     // trip pin value (0)
  output wire overtemp_trip_n_oe_out,  // trip pin pulled low
  output wire alert_n_out,             // alarm pin value (0)
  output wire alert_n_oe_out,          // alarm pin pulled low
  input wire [11:0] local_adc_in,      // signed local reading, 1/8 c
  input wire [11:0] remote_adc_in,     // signed remote reading, 1/8 c
  input wire remote_diode_pos_fault_in, // positive diode pin open
  input wire remote_diode_neg_fault_in, // diode pins shorted
  output wire busy_out                 // conversion in progress
);
  localparam CW = 32;
  // conversion sequencer states
  localparam S_IDLE = 2'd0;
  localparam S_LOC = 2'd1;
  localparam S_REM = 2'd2;
  localparam S_WAIT = 2'd3;
  wire [7:0] cmd, wdata;
  wire wr, rd, ara, stop, stall;
  reg [7:0] rdata;
  reg [7:0] loc_whole_r, rem_whole_r, loc_frac_r, rem_frac_r;
  reg [7:0] cfg_r, rate_r, overtemp_trip_n_r;
  reg [7:0] lhi_r, llo_r, rhi_r, rlo_r;
  reg [10:0] loc_smp_r, rem_smp_r;
  reg rem_flt_r, alert_r, overtemp_trip_n_act_r, oneshot_r;
  reg [1:0] st_r;
  reg [CW-1:0] cnt_r, rate_cnt_r;
  wire standby = cfg_r[`DTR_CFG_STANDBY_BIT];
  // whole-degree parts of the held samples
  wire [7:0] lw = loc_smp_r[10:3];
  wire [7:0] rw = rem_smp_r[10:3];
  // limit conditions, recomputed from the latest samples
  wire cond_l = (lw > lhi_r) || (lw < llo_r);
  wire cond_r = !rem_flt_r && ((rw > rhi_r) || (rw < rlo_r));
  wire cond_f = rem_flt_r && cfg_r[`DTR_CFG_FAULT_EN_BIT];
  wire cond = cond_l || cond_r || cond_f;
  wire rd_status = rd && cmd == `DTR_REG_STATUS;
  // clamp a signed 1/8 c sample to unsigned 11 bits
  function [10:0] clamp11;
    input [11:0] v;
    begin
      clamp11 = v[11] ? 11'h000 : v[10:0];
    end
  endfunction
  // ********************************************************
  // serial slave
  // ********************************************************
  dtr_serial #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_serial (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .cmd_out(cmd),
    .wr_out(wr),
    .wdata_out(wdata),
    .rd_out(rd),
    .rdata_in(rdata),
    .ara_out(ara),
    .alert_in(alert_r),
    .stop_out(stop),
    .stall_out(stall)
  );
  // open-drain pins: value fixed low, the enable pulls the line
  assign sda_out = 1'b0;
  assign overtemp_trip_n_out = 1'b0;
  assign alert_n_out = 1'b0;
  assign overtemp_trip_n_oe_out = overtemp_trip_n_act_r;
  assign alert_n_oe_out = alert_r;
  assign busy_out = (st_r == S_LOC) || (st_r == S_REM);
  // ********************************************************
  // register read mux
  // ********************************************************
  always @* begin
    case (cmd)
      `DTR_REG_LOCAL_WHOLE: rdata = loc_whole_r;
      `DTR_REG_REMOTE_WHOLE: rdata = rem_whole_r;
      `DTR_REG_REMOTE_FRAC: rdata = rem_frac_r;
      `DTR_REG_LOCAL_FRAC: rdata = loc_frac_r;
      `DTR_REG_STATUS:
        rdata = {busy_out, 1'b0, 1'b0, cond_f, cond_l, cond_r,
                 overtemp_trip_n_act_r, alert_r};
      `DTR_REG_CONFIG: rdata = cfg_r;
      `DTR_REG_RATE: rdata = rate_r;
      `DTR_REG_LOCAL_HIGH: rdata = lhi_r;
      `DTR_REG_LOCAL_LOW: rdata = llo_r;
      `DTR_REG_REMOTE_HIGH: rdata = rhi_r;
      `DTR_REG_REMOTE_LOW: rdata = rlo_r;
      `DTR_REG_OVERTEMP_TRIP_N_LIMIT: rdata = overtemp_trip_n_r;
      default: rdata = 8'h00;
    endcase
  end
  // ********************************************************
  // writable registers, conversion sequencer, alarms
  // ********************************************************
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_r <= 8'h00;
      rate_r <= `DTR_RATE_RST;
      overtemp_trip_n_r <= `DTR_OVERTEMP_TRIP_N_RST;
      lhi_r <= `DTR_LIMIT_HIGH_RST;
      rhi_r <= `DTR_LIMIT_HIGH_RST;
      llo_r <= `DTR_LIMIT_LOW_RST;
      rlo_r <= `DTR_LIMIT_LOW_RST;
      loc_whole_r <= 8'h00;
      rem_whole_r <= 8'h00;
      loc_frac_r <= 8'h00;
      rem_frac_r <= 8'h00;
      loc_smp_r <= 11'h000;
      rem_smp_r <= 11'h000;
      rem_flt_r <= 1'b0;
      alert_r <= 1'b0;
      overtemp_trip_n_act_r <= 1'b0;
      oneshot_r <= 1'b0;
      st_r <= S_IDLE;
      cnt_r <= {CW{1'b0}};
      rate_cnt_r <= {CW{1'b0}};
    end else begin
      // host writes; read-only and unmapped offsets are ignored
      if (wr) begin
        case (cmd)
          `DTR_REG_CONFIG: cfg_r <= wdata;
          `DTR_REG_RATE: rate_r <= wdata;
          `DTR_REG_LOCAL_HIGH: lhi_r <= wdata;
          `DTR_REG_LOCAL_LOW: llo_r <= wdata;
          `DTR_REG_REMOTE_HIGH: rhi_r <= wdata;
          `DTR_REG_REMOTE_LOW: rlo_r <= wdata;
          `DTR_REG_OVERTEMP_TRIP_N_LIMIT: overtemp_trip_n_r <= wdata;
          `DTR_REG_ONESHOT: oneshot_r <= 1'b1;
          default: begin
          end
        endcase
      end
      // trip follows the latest samples, no latch
      overtemp_trip_n_act_r <= (lw > overtemp_trip_n_r) || (!rem_flt_r && rw > overtemp_trip_n_r);
      // set wins over acknowledge; clears only once fault gone
      if (cond)
        alert_r <= 1'b1;
      else if (rd_status || ara)
        alert_r <= 1'b0;
      // conversion sequence, both channels every time
      case (st_r)
        S_IDLE: begin
          rate_cnt_r <= rate_cnt_r + 1'b1;
          // armed one shot starts at stop, free run after the gap
          if ((oneshot_r && stop) || (!standby &&
              rate_cnt_r >= RATE_UNIT_CYC * (rate_r + 1))) begin
            st_r <= S_LOC;
            cnt_r <= {CW{1'b0}};
            oneshot_r <= 1'b0;
          end
        end
        S_LOC: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= INTEG_CYC - 1) begin
            loc_smp_r <= clamp11(local_adc_in);
            st_r <= S_REM;
          end
        end
        S_REM: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= 2 * INTEG_CYC - 1) begin
            rem_smp_r <= clamp11(remote_adc_in);
            // diode fault sampled together with the remote reading
            rem_flt_r <= remote_diode_pos_fault_in |
                         remote_diode_neg_fault_in;
            st_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= CONV_CYC - 1) begin
            // whole and fraction move together
            loc_whole_r <= lw;
            loc_frac_r <= {loc_smp_r[2:0], 5'h00};
            rem_whole_r <= rem_flt_r ? `DTR_FAULT_CODE : rw;
            rem_frac_r <= rem_flt_r ? 8'h00 : {rem_smp_r[2:0], 5'h00};
            st_r <= S_IDLE;
            rate_cnt_r <= {CW{1'b0}};
          end
        end
        default: st_r <= S_IDLE;
      endcase
      // a standby write mid-sequence drops it; old results stay
      if (wr && cmd == `DTR_REG_CONFIG && !standby &&
          wdata[`DTR_CFG_STANDBY_BIT] && st_r != S_IDLE) begin
        st_r <= S_IDLE;
      end
    end
  end
endmodule

// ---- design/dtr_defs.vh ----
// constants for the dual channel temperature readout core
`ifndef DTR_DEFS_VH
`define DTR_DEFS_VH
`define DTR_CLK_MHZ 200
`define DTR_TIMEOUT_MIN_MS 25
`define DTR_TIMEOUT_MAX_MS 55
`define DTR_TIMEOUT_CYC (`DTR_TIMEOUT_MIN_MS * 1000 * `DTR_CLK_MHZ + 1)
`define DTR_INTEG_MS 60
`define DTR_INTEG_CYC (`DTR_INTEG_MS * 1000 * `DTR_CLK_MHZ)
`define DTR_CONV_MS 125
`define DTR_CONV_CYC (`DTR_CONV_MS * 1000 * `DTR_CLK_MHZ)
`define DTR_REG_LOCAL_WHOLE 8'h00
`define DTR_REG_REMOTE_WHOLE 8'h01
`define DTR_REG_STATUS 8'h02
`define DTR_REG_CONFIG 8'h03
`define DTR_REG_RATE 8'h04
`define DTR_REG_ONESHOT 8'h0f
`define DTR_REG_REMOTE_FRAC 8'h10
`define DTR_REG_LOCAL_FRAC 8'h11
`define DTR_REG_LOCAL_HIGH 8'h05
`define DTR_REG_LOCAL_LOW 8'h06
`define DTR_REG_REMOTE_HIGH 8'h07
`define DTR_REG_REMOTE_LOW 8'h08
`define DTR_REG_OVERTEMP_TRIP_N_LIMIT 8'h20
`define DTR_REG_SLAVE_ADDR 7'h4c
`define DTR_ALERT_RESP_ADDR 7'h0c
`define DTR_FAULT_CODE 8'hff
`define DTR_CFG_STANDBY_BIT 6
`define DTR_CFG_FAULT_EN_BIT 0
`define DTR_LIMIT_HIGH_RST 8'h46
`define DTR_LIMIT_LOW_RST 8'h00
`define DTR_OVERTEMP_TRIP_N_RST 8'h55
`define DTR_RATE_RST 8'h00
`endif

// ---- design/dtr_serial.v ----
// two-wire serial slave: byte framing, start/stop, stall timeout
`include "dtr_defs.vh"
module dtr_serial #(
  parameter TIMEOUT_CYC = `DTR_TIMEOUT_CYC
) (
  input wire clk_in,          // core clock
  input wire rst_in,          // async reset, high
  input wire scl_in,          // serial clock level
  input wire sda_in,          // serial data level
  output reg sda_oe_out,      // pull data low while high
  output reg [7:0] cmd_out,   // selected register
  output reg wr_out,          // one-cycle write strobe
  output reg [7:0] wdata_out, // write data
  output reg rd_out,          // one-cycle read-byte fetch strobe
  input wire [7:0] rdata_in,  // data to send
  output reg ara_out,         // alert response byte sent pulse
  input wire alert_in,        // alert level, answers ara
  output reg stop_out,        // stop condition pulse
  output reg stall_out        // timeout reset pulse
);
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_CMD = 3'd2;
  localparam ST_WDAT = 3'd3;
  localparam ST_RDAT = 3'd4;
  localparam ST_ACK = 3'd5;
  localparam ST_MACK = 3'd6;
  localparam ST_ARA = 3'd7;
  localparam CW = 24;
  localparam [7:0] ARA_BYTE = {`DTR_REG_SLAVE_ADDR, 1'b1};
  reg scl_d_r, sda_d_r;
  reg [2:0] st_r, nx_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg rd_mode_r, ara_mode_r;
  reg [CW-1:0] to_r;
  wire scl_rise = scl_in & ~scl_d_r;
  wire scl_fall = ~scl_in & scl_d_r;
  wire start = scl_in & scl_d_r & sda_d_r & ~sda_in;
  wire stop = scl_in & scl_d_r & ~sda_d_r & sda_in;
  wire stalled = (to_r >= TIMEOUT_CYC[CW-1:0]);
  // ********************************************************
  // byte engine, stalled-clock timer
  // ********************************************************
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      st_r <= ST_IDLE;
      nx_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rd_mode_r <= 1'b0;
      ara_mode_r <= 1'b0;
      to_r <= {CW{1'b0}};
      sda_oe_out <= 1'b0;
      cmd_out <= 8'h00;
      wr_out <= 1'b0;
      wdata_out <= 8'h00;
      rd_out <= 1'b0;
      ara_out <= 1'b0;
      stop_out <= 1'b0;
      stall_out <= 1'b0;
    end else begin
      scl_d_r <= scl_in;
      sda_d_r <= sda_in;
      wr_out <= 1'b0;
      rd_out <= 1'b0;
      ara_out <= 1'b0;
      stop_out <= 1'b0;
      stall_out <= 1'b0;
      // count only while clock low; own time base
      if (scl_in || scl_rise)
        to_r <= {CW{1'b0}};
      else if (!stalled)
        to_r <= to_r + 1'b1;
      if (stalled && st_r != ST_IDLE) begin
        st_r <= ST_IDLE; // stuck bus returns to idle
        sda_oe_out <= 1'b0;
        stall_out <= 1'b1;
      end else if (stop) begin
        st_r <= ST_IDLE;
        sda_oe_out <= 1'b0;
        stop_out <= 1'b1;
      end else if (start) begin
        st_r <= ST_ADDR;
        bit_r <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        case (st_r)
          ST_ADDR, ST_CMD, ST_WDAT: begin
            sh_r <= {sh_r[6:0], sda_in};
            bit_r <= bit_r + 4'h1;
          end
          ST_MACK: begin
            if (sda_in)
              st_r <= ST_IDLE; // master nack ends read
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (st_r)
          ST_ADDR: begin
            if (bit_r == 4'h8) begin
              rd_mode_r <= sh_r[0];
              ara_mode_r <= 1'b0;
              if (sh_r[7:1] == `DTR_REG_SLAVE_ADDR) begin
                sda_oe_out <= 1'b1;
                st_r <= ST_ACK;
                nx_r <= sh_r[0] ? ST_RDAT : ST_CMD;
                if (sh_r[0])
                  rd_out <= 1'b1;
              end else if (sh_r[7:1] == `DTR_ALERT_RESP_ADDR &&
                           sh_r[0] && alert_in) begin
                sda_oe_out <= 1'b1;
                st_r <= ST_ACK;
                nx_r <= ST_RDAT;
                ara_mode_r <= 1'b1;
              end else
                st_r <= ST_IDLE;
            end
          end
          ST_CMD, ST_WDAT: begin
            if (bit_r == 4'h8) begin
              sda_oe_out <= 1'b1;
              st_r <= ST_ACK;
              if (st_r == ST_CMD)
                cmd_out <= sh_r;
              else begin
                wdata_out <= sh_r;
                wr_out <= 1'b1;
              end
              nx_r <= ST_WDAT;
            end
          end
          ST_ACK: begin
            sda_oe_out <= 1'b0;
            bit_r <= 4'h0;
            st_r <= nx_r;
            if (nx_r == ST_RDAT) begin
              sh_r <= ara_mode_r ? ARA_BYTE : rdata_in;
              sda_oe_out <= ara_mode_r ? ~ARA_BYTE[7] : ~rdata_in[7];
              bit_r <= 4'h1;
            end
          end
          ST_RDAT: begin
            if (bit_r == 4'h8) begin
              sda_oe_out <= 1'b0;
              st_r <= ST_MACK;
              if (ara_mode_r)
                ara_out <= 1'b1; // alert acknowledged by response
            end else begin
              sda_oe_out <= ~sh_r[7 - bit_r[2:0]];
              bit_r <= bit_r + 4'h1;
            end
          end
          ST_MACK: begin
            st_r <= ST_IDLE;
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// ---- verif/dtr_core_props.sv ----
// port checker for the temperature readout core
module dtr_core_props #(
  parameter TIMEOUT_CYC = 200,
  parameter CONV_CYC = 120
) (
  input wire clk_in,                 // core clock
  input wire rst_in,                 // async reset, high
  input wire scl_in,                 // serial clock level
  input wire sda_in,                 // serial data level
  input wire sda_out,                // data drive value
  input wire sda_oe_out,             // data pulled low
  input wire overtemp_trip_n_out,    // trip pin value
  input wire overtemp_trip_n_oe_out, // trip pin pulled low
  input wire alert_n_out,            // alarm pin value
  input wire alert_n_oe_out,         // alarm pin pulled low
  input wire busy_out                // conversion running
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STALL_MAX = TIMEOUT_CYC + 8;
  localparam int BUSY_MAX = CONV_CYC + 2;
  reg [15:0] low_cnt_r;
  reg [15:0] idle_cnt_r;
  reg [15:0] quiet_cnt_r;
  reg [15:0] busy_cnt_r;
  // ************************************************************
  // helper counters and properties
  // ************************************************************
  // run counters of clock low, idle bus, quiet core (saturating) and busy (wrapping)
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt_r <= 16'h0000;
      idle_cnt_r <= 16'h0000;
      quiet_cnt_r <= 16'h0000;
      busy_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= scl_in ? 16'h0000 : low_cnt_r + {15'h0000, ~&low_cnt_r};
      idle_cnt_r <= (scl_in & sda_in) ?
        idle_cnt_r + {15'h0000, ~&idle_cnt_r} : 16'h0000;
      quiet_cnt_r <= (scl_in & ~busy_out) ?
        quiet_cnt_r + {15'h0000, ~&quiet_cnt_r} : 16'h0000;
      busy_cnt_r <= busy_out ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_reset_end;
    $fell(rst_in);
  endsequence
  sequence s_conv_end;
    $fell(busy_out);
  endsequence
  sequence s_conv_gap;
    !busy_out [*8];
  endsequence
  a_reset_quiet: assert property (s_reset_end |->
    !alert_n_oe_out && !overtemp_trip_n_oe_out && !sda_oe_out)
    else $error("outputs not released after reset");
  a_pins_open_drain: assert property (
    !sda_out && !overtemp_trip_n_out && !alert_n_out)
    else $error("open drain pin drives high");
  a_stall_release: assert property (
    low_cnt_r > STALL_MAX |-> !sda_oe_out)
    else $error("data held low past stall limit");
  a_data_edge: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed while clock high");
  a_busy_bound: assert property (busy_cnt_r <= BUSY_MAX)
    else $error("conversion longer than limit");
  a_conv_gap: assert property (s_conv_end |-> s_conv_gap)
    else $error("conversion restarted without gap");
  a_alert_idle: assert property (
    idle_cnt_r > 16'd40 |-> !$fell(alert_n_oe_out))
    else $error("alarm cleared without acknowledge");
  a_quiet_outputs: assert property (quiet_cnt_r > 16'd40 |->
    $stable(overtemp_trip_n_oe_out) && !$rose(alert_n_oe_out))
    else $error("alarm moved without conversion");
endmodule
bind dtr_core dtr_core_props u_props (.clk_in, .rst_in, .scl_in, .sda_in,
  .sda_out, .sda_oe_out, .overtemp_trip_n_out, .overtemp_trip_n_oe_out,
  .alert_n_out, .alert_n_oe_out, .busy_out);

// ---- verif/dtr_core_tb.sv ----
// self-checking bench for the temperature readout core
`include "dtr_defs.vh"
module dtr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam INTEG = 50;
  localparam CONV = 120;
  localparam [7:0] SLV_W = {`DTR_REG_SLAVE_ADDR, 1'b0};
  localparam [7:0] SLV_R = {`DTR_REG_SLAVE_ADDR, 1'b1};
  reg clk_in = 1'b0;
  reg rst_in = 1'b1;
  reg [11:0] local_adc = 12'h0cb;
  reg [11:0] remote_adc = 12'h415;
  reg pos_fault = 1'b0;
  reg neg_fault = 1'b0;
  reg a;
  reg [7:0] d;
  integer fails = 0;
  integer n_compared = 0;
  integer k;
  wire scl, host_oe, sda_oe, sda_v, trip_v, trip_oe, alert_v, alert_oe, busy;
  wire sda = ~(sda_oe | host_oe); // pulled-up shared data wire
  // ************************************************************
  // clock, host model, device
  // ************************************************************
  always #2.5 clk_in = ~clk_in;
  dtr_host u_host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(host_oe));
  dtr_core #(.TIMEOUT_CYC(200), .INTEG_CYC(INTEG), .CONV_CYC(CONV),
    .RATE_UNIT_CYC(100)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_v), .sda_oe_out(sda_oe),
    .overtemp_trip_n_out(trip_v), .overtemp_trip_n_oe_out(trip_oe),
    .alert_n_out(alert_v), .alert_n_oe_out(alert_oe),
    .local_adc_in(local_adc), .remote_adc_in(remote_adc),
    .remote_diode_pos_fault_in(pos_fault),
    .remote_diode_neg_fault_in(neg_fault), .busy_out(busy));
  // compare helpers, one per result kind
  task chk8(input [8*8-1:0] name, input [7:0] exp, input [7:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task chk1(input [8*8-1:0] name, input exp, input got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %b seen %b", name, exp, got);
      end
    end
  endtask
  // read byte and write byte frames
  task rd_reg(input [7:0] cmd, output [7:0] data);
    reg a0, a1, a2;
    begin
      u_host.bus_start;
      u_host.put_byte(SLV_W, a0);
      u_host.put_byte(cmd, a1);
      u_host.bus_start;
      u_host.put_byte(SLV_R, a2);
      u_host.get_byte(data, 1'b1);
      u_host.bus_stop;
      chk1("ack", 1'b0, a0 | a1 | a2);
    end
  endtask
  task rd_chk(input [7:0] cmd, input [7:0] exp);
    begin
      rd_reg(cmd, d);
      chk8("register", exp, d);
    end
  endtask
  task wr_reg(input [7:0] cmd, input [7:0] data);
    reg a0, a1, a2;
    begin
      u_host.bus_start;
      u_host.put_byte(SLV_W, a0);
      u_host.put_byte(cmd, a1);
      u_host.put_byte(data, a2);
      u_host.bus_stop;
      chk1("ack", 1'b0, a0 | a1 | a2);
    end
  endtask
  // waits for n conversion ends, then for the results to land
  task wait_conv(input integer n);
    begin
      repeat (n) begin
        k = 0;
        while (busy !== 1'b1 && k < 1000) begin
          @(negedge clk_in);
          k = k + 1;
        end
        while (busy !== 1'b0 && k < 1000) begin
          @(negedge clk_in);
          k = k + 1;
        end
        if (k >= 1000) fails = fails + 1;
      end
      u_host.tick(30);
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #400us;
    fails = fails + 1;
    test_done;
  end
  // main sequence
  initial begin
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    chk1("trip", 1'b0, trip_oe);
    chk1("alert", 1'b0, alert_oe);
    wait_conv(2);
    rd_chk(`DTR_REG_LOCAL_WHOLE, local_adc[10:3]);
    rd_chk(`DTR_REG_LOCAL_FRAC, {local_adc[2:0], 5'h00});
    rd_chk(`DTR_REG_REMOTE_WHOLE, remote_adc[10:3]);
    rd_chk(`DTR_REG_REMOTE_FRAC, {remote_adc[2:0], 5'h00});
    chk1("trip", 1'b1, trip_oe);
    chk1("alert", 1'b1, alert_oe);
    // unmapped read, read-only write, foreign address
    rd_chk(8'h3e, 8'h00);
    wr_reg(`DTR_REG_LOCAL_WHOLE, 8'h77);
    rd_chk(`DTR_REG_LOCAL_WHOLE, local_adc[10:3]);
    u_host.bus_start;
    u_host.put_byte(8'ha0, a);
    u_host.bus_stop;
    chk1("nack", 1'b1, a);
    // condition gone: alarm stays latched until the status read
    local_adc = 12'h004;
    remote_adc = 12'h0c8;
    wait_conv(2);
    chk1("trip", 1'b0, trip_oe);
    chk1("alert", 1'b1, alert_oe);
    rd_reg(`DTR_REG_STATUS, d);
    chk1("alert", 1'b0, alert_oe);
    local_adc = 12'hff4;
    wait_conv(2);
    rd_chk(`DTR_REG_LOCAL_WHOLE, 8'h00);
    // device sends a zero bit while the clock is held low, then releases it past the stall limit
    u_host.bus_start;
    u_host.put_byte(SLV_R, a);
    u_host.hold_low(140);
    chk1("drive", 1'b1, sda_oe);
    u_host.hold_low(120);
    chk1("drive", 1'b0, sda_oe);
    u_host.bus_stop;
    rd_chk(`DTR_REG_REMOTE_WHOLE, remote_adc[10:3]);
    // shorted then open remote diode
    neg_fault = 1'b1;
    wr_reg(`DTR_REG_CONFIG, 8'h01);
    wait_conv(2);
    rd_chk(`DTR_REG_REMOTE_WHOLE, `DTR_FAULT_CODE);
    rd_chk(`DTR_REG_REMOTE_FRAC, 8'h00);
    chk1("alert", 1'b1, alert_oe);
    neg_fault = 1'b0;
    pos_fault = 1'b1;
    wait_conv(2);
    rd_chk(`DTR_REG_REMOTE_WHOLE, `DTR_FAULT_CODE);
    pos_fault = 1'b0;
    // standby halts free running, one shot still converts both
    wr_reg(`DTR_REG_CONFIG, 8'h41);
    u_host.tick(130);
    k = 0;
    repeat (400) begin
      @(negedge clk_in);
      if (busy !== 1'b0) k = k + 1;
    end
    chk1("idle", 1'b1, k == 0);
    local_adc = 12'h1f8;
    wr_reg(`DTR_REG_ONESHOT, 8'h00);
    chk1("busy", 1'b1, busy);
    k = 0;
    while (busy === 1'b1 && k < 300) begin
      @(negedge clk_in);
      k = k + 1;
    end
    chk1("span", 1'b1, k >= 2 * INTEG - 16 && k <= CONV);
    u_host.tick(30);
    rd_chk(`DTR_REG_LOCAL_WHOLE, local_adc[10:3]);
    rd_chk(`DTR_REG_REMOTE_WHOLE, remote_adc[10:3]);
    // alert response clears the latched alarm once the fault is gone
    chk1("alert", 1'b1, alert_oe);
    u_host.bus_start;
    u_host.put_byte({`DTR_ALERT_RESP_ADDR, 1'b1}, a);
    u_host.get_byte(d, 1'b1);
    u_host.bus_stop;
    chk1("ara ack", 1'b0, a);
    chk8("ara addr", SLV_R, d);
    chk1("alert", 1'b0, alert_oe);
    u_host.bus_start;
    u_host.put_byte({`DTR_ALERT_RESP_ADDR, 1'b1}, a);
    u_host.bus_stop;
    chk1("ara nack", 1'b1, a);
    test_done;
  end
endmodule

// ---- verif/dtr_host.sv ----
// two-wire bus host model driving serial clock and data
module dtr_host (
  input wire clk_in,     // time base
  input wire sda_in,     // resolved data wire level
  output reg scl_out,    // serial clock, idles high
  output reg sda_oe_out  // pulls data low while high
);
  timeunit 1ns;
  timeprecision 1ps;
  reg smp_r;
  // ************************************************************
  // bus cycles, changed only at falling clock edges
  // ************************************************************
  // bus idles released with the clock standing high
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task tick(input integer n);
    repeat (n) @(negedge clk_in);
  endtask
  // one bit: data set in the low phase, sampled mid high phase
  task bit_cyc(input b);
    begin
      sda_oe_out = ~b;
      tick(4);
      scl_out = 1'b1;
      tick(4);
      smp_r = sda_in;
      tick(4);
      scl_out = 1'b0;
      tick(4);
    end
  endtask
  task bus_start;
    begin
      sda_oe_out = 1'b0;
      tick(4);
      scl_out = 1'b1;
      tick(8);
      sda_oe_out = 1'b1;
      tick(8);
      scl_out = 1'b0;
      tick(4);
    end
  endtask
  task bus_stop;
    begin
      sda_oe_out = 1'b1;
      tick(4);
      scl_out = 1'b1;
      tick(8);
      sda_oe_out = 1'b0;
      tick(8);
    end
  endtask
  // msb first, ninth bit carries the acknowledge
  task put_byte(input [7:0] b, output ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_cyc(b[i]);
      end
      bit_cyc(1'b1);
      ack = smp_r;
    end
  endtask
  task get_byte(output [7:0] b, input nack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_cyc(1'b1);
        b[i] = smp_r;
      end
      bit_cyc(nack);
    end
  endtask
  // keeps the clock low, the only way a frame exceeds the stall limit
  task hold_low(input integer n);
    tick(n);
  endtask
endmodule
